// ---- hw/rx_cfg_pkg.sv ----
// constants and types for the receiver channel and synthesizer configuration registers
package rx_cfg_pkg;
	localparam logic [8:0] OFS_CHANNEL_CONFIG = 9'h058;
	localparam logic [8:0] OFS_PLL_INTEGER_BAND = 9'h059;
	localparam logic [8:0] OFS_PLL_FRACTION_LOW = 9'h05A;
	localparam logic [8:0] OFS_PLL_FRACTION_MID = 9'h05B;
	localparam logic [8:0] OFS_PLL_FRACTION_HIGH = 9'h05C;
	localparam logic [8:0] OFS_PAGE_SELECT = 9'h080;
	localparam logic [8:0] PAGE1_BASE = 9'h100;
	localparam logic [7:0] RST_CHANNEL_CONFIG = 8'h04;
	localparam logic [7:0] RST_PLL_INTEGER_BAND = 8'h93;
	localparam logic [7:0] RST_PLL_FRACTION_LOW = 8'hF3;
	localparam logic [7:0] RST_PLL_FRACTION_MID = 8'h07;
	localparam logic [7:0] RST_PLL_FRACTION_HIGH = 8'h09;
	localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
	// writable bit masks, zeros are unused bits
	localparam logic [7:0] MASK_CHANNEL_CONFIG = 8'h7F;
	localparam logic [7:0] MASK_PLL_FRACTION_HIGH = 8'h3F;
	localparam logic [7:0] MASK_PAGE_SELECT = 8'h01;
	localparam int POS_EXT_PROC = 5;
	localparam int POS_RESUME_POLL = 4;
	localparam int POS_CHANNEL_COUNT = 2;
	localparam int POS_MODULATION = 0;
	localparam int POS_BAND = 6;
	localparam int POS_SPUR_COMP = 5;
	localparam int FRACTION_WIDTH = 21;
	localparam logic [1:0] EXT_PROC_NONE = 2'h0;
	localparam logic [1:0] EXT_PROC_CHIP = 2'h1;
	localparam logic [1:0] EXT_PROC_DATA_MF = 2'h2;
	localparam logic [1:0] BAND_UNUSED = 2'h0;
	// register access from the spi front end
	typedef struct packed {
		logic valid;
		logic write;
		logic [8:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// block controls derived from the processing mode
	typedef struct packed {
		logic chip_data_rx_mode;
		logic matched_filter_rx_mode;
		logic raw_data_rx_mode;
		logic framing_enable;
		logic frame_interrupts_enable;
		logic sync_timeout_timer_enable;
		logic timeout_timer_enable;
		logic wakeup_as_sync;
		logic wakeup_level_only;
	} proc_ctrl_t;
	// demodulation per operating mode, 1 = FSK
	typedef struct packed {
		logic fsk_slave_run;
		logic fsk_polling;
		logic fsk_self_poll_run;
	} demod_sel_t;
	typedef enum logic [2:0] {
		BAND_915_868 = 3'b001,
		BAND_434 = 3'b010,
		BAND_315 = 3'b100
	} band_t;
endpackage

// ---- hw/rx_channel_pll_config_regs.sv ----
// register group for channel configuration, synthesizer divider and page select
`timescale 1ns/1ps
`default_nettype none
module rx_channel_pll_config_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire rx_cfg_pkg::reg_req_t req,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic page_select,
	output rx_cfg_pkg::proc_ctrl_t proc_ctrl,
	output logic resume_polling_after_message_end,
	output logic channel_count,
	output logic channel1_select,
	output rx_cfg_pkg::demod_sel_t demod_sel,
	output rx_cfg_pkg::band_t band_select,
	output logic [5:0] divider_integer_ch1,
	output logic [20:0] divider_fraction_ch1,
	output logic spur_compensation_enable_ch1,
	output logic illegal_write
);
	logic [7:0] channel_config;
	logic [7:0] pll_integer_band_ch1;
	logic [7:0] pll_fraction_low_ch1;
	logic [7:0] pll_fraction_mid_ch1;
	logic [7:0] pll_fraction_high_ch1;
	logic [7:0] register_page_select;
	logic [8:0] page_addr;
	logic wr;
	logic [1:0] wr_proc;
	logic [1:0] wr_band;
	logic [1:0] modulation_type;
	logic wr_cfg;
	logic wr_int;

	// decoded enables per processing mode, mode 11 falls back to all active
	localparam rx_cfg_pkg::proc_ctrl_t PROC_ALL_ACTIVE =
		'{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	localparam rx_cfg_pkg::proc_ctrl_t PROC_CHIP_DATA =
		'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	localparam rx_cfg_pkg::proc_ctrl_t PROC_FILTER_DATA =
		'{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	////////////////////////////////////////////////////////////////
	// address decode
	// page-relative address: page 1 accesses land above 100
	assign page_addr = register_page_select[0] ?
		(req.addr | rx_cfg_pkg::PAGE1_BASE) : req.addr;
	assign wr = req.valid & req.write;
	assign wr_proc = req.wdata[rx_cfg_pkg::POS_EXT_PROC +: 2];
	assign wr_band = req.wdata[rx_cfg_pkg::POS_BAND +: 2];
	// page bit straight from its storage flop
	assign page_select = register_page_select[0];

	// address match shared by the write decodes and the page register read
	function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
		hit = (a == ofs);
	endfunction

	// write strobes shared by storage and the unused-code flag
	assign wr_cfg = wr && hit(page_addr, rx_cfg_pkg::OFS_CHANNEL_CONFIG);
	assign wr_int = wr && hit(page_addr, rx_cfg_pkg::OFS_PLL_INTEGER_BAND);

	////////////////////////////////////////////////////////////////
	// register storage
	// channel configuration, unused bits masked off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			channel_config <= rx_cfg_pkg::RST_CHANNEL_CONFIG;
		end else if (wr_cfg) begin
			channel_config <= req.wdata & rx_cfg_pkg::MASK_CHANNEL_CONFIG;
		end
	end

	// integer divider and band
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_integer_band_ch1 <= rx_cfg_pkg::RST_PLL_INTEGER_BAND;
		end else if (wr_int) begin
			pll_integer_band_ch1 <= req.wdata;
		end
	end

	// fraction bytes, low, middle, top five plus spur enable
	// no latching: each byte applies alone, so the ratio is mixed between writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_fraction_low_ch1 <= rx_cfg_pkg::RST_PLL_FRACTION_LOW;
			pll_fraction_mid_ch1 <= rx_cfg_pkg::RST_PLL_FRACTION_MID;
			pll_fraction_high_ch1 <= rx_cfg_pkg::RST_PLL_FRACTION_HIGH;
		end else if (wr) begin
			if (hit(page_addr, rx_cfg_pkg::OFS_PLL_FRACTION_LOW)) begin
				pll_fraction_low_ch1 <= req.wdata;
			end
			if (hit(page_addr, rx_cfg_pkg::OFS_PLL_FRACTION_MID)) begin
				pll_fraction_mid_ch1 <= req.wdata;
			end
			if (hit(page_addr, rx_cfg_pkg::OFS_PLL_FRACTION_HIGH)) begin
				pll_fraction_high_ch1 <= req.wdata & rx_cfg_pkg::MASK_PLL_FRACTION_HIGH;
			end
		end
	end

	// page select answers at its offset on either page
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			register_page_select <= rx_cfg_pkg::RST_PAGE_SELECT;
		end else if (wr && hit(req.addr, rx_cfg_pkg::OFS_PAGE_SELECT)) begin
			register_page_select <= req.wdata & rx_cfg_pkg::MASK_PAGE_SELECT;
		end
	end

	////////////////////////////////////////////////////////////////
	// read port, one cycle after the request
	// page register decodes on the raw address so page 1 can still return
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= req.valid & ~req.write;
			if (req.valid && !req.write) begin
				if (hit(req.addr, rx_cfg_pkg::OFS_PAGE_SELECT)) begin
					rdata <= register_page_select;
				end else begin
					unique case (page_addr)
						rx_cfg_pkg::OFS_CHANNEL_CONFIG: rdata <= channel_config;
						rx_cfg_pkg::OFS_PLL_INTEGER_BAND: rdata <= pll_integer_band_ch1;
						rx_cfg_pkg::OFS_PLL_FRACTION_LOW: rdata <= pll_fraction_low_ch1;
						rx_cfg_pkg::OFS_PLL_FRACTION_MID: rdata <= pll_fraction_mid_ch1;
						rx_cfg_pkg::OFS_PLL_FRACTION_HIGH: rdata <= pll_fraction_high_ch1;
						default: rdata <= 8'h00;
					endcase
				end
			end
		end
	end

	// flags a write of an unused processing or band code
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			illegal_write <= 1'b0;
		end else begin
			illegal_write <= (wr_cfg && wr_proc == 2'h3) ||
				(wr_int && wr_band == rx_cfg_pkg::BAND_UNUSED);
		end
	end

	////////////////////////////////////////////////////////////////
	// decoded controls, registered from the stored fields
	assign modulation_type = channel_config[rx_cfg_pkg::POS_MODULATION +: 2];

	// processing mode to block enables
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			proc_ctrl <= PROC_ALL_ACTIVE;
		end else begin
			unique case (channel_config[rx_cfg_pkg::POS_EXT_PROC +: 2])
				rx_cfg_pkg::EXT_PROC_CHIP:
					proc_ctrl <= PROC_CHIP_DATA;
				rx_cfg_pkg::EXT_PROC_DATA_MF:
					proc_ctrl <= PROC_FILTER_DATA;
				default:
					proc_ctrl <= PROC_ALL_ACTIVE;
			endcase
		end
	end

	// channel count and polling behaviour after message end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resume_polling_after_message_end <=
				rx_cfg_pkg::RST_CHANNEL_CONFIG[rx_cfg_pkg::POS_RESUME_POLL];
			channel_count <= rx_cfg_pkg::RST_CHANNEL_CONFIG[rx_cfg_pkg::POS_CHANNEL_COUNT];
			channel1_select <= 1'b1;
		end else begin
			resume_polling_after_message_end <= channel_config[rx_cfg_pkg::POS_RESUME_POLL];
			channel_count <= channel_config[rx_cfg_pkg::POS_CHANNEL_COUNT];
			channel1_select <= 1'b1;
		end
	end

	// demodulation per operating mode, reset is ASK everywhere
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			demod_sel <= '{1'b0, 1'b0, 1'b0};
		end else begin
			// bit 0 picks FSK for both run modes, bit 1 flips the polling phase
			demod_sel.fsk_slave_run <= modulation_type[0];
			demod_sel.fsk_polling <= modulation_type[0] ^ modulation_type[1];
			demod_sel.fsk_self_poll_run <= modulation_type[0];
		end
	end

	// band one-hot, an unused code holds the last legal band
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			band_select <= rx_cfg_pkg::BAND_434;
		end else begin
			unique case (pll_integer_band_ch1[rx_cfg_pkg::POS_BAND +: 2])
				2'h1: band_select <= rx_cfg_pkg::BAND_915_868;
				2'h2: band_select <= rx_cfg_pkg::BAND_434;
				2'h3: band_select <= rx_cfg_pkg::BAND_315;
				default: band_select <= band_select; // unused code holds last band
			endcase
		end
	end

	// divider values and spur enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divider_integer_ch1 <= rx_cfg_pkg::RST_PLL_INTEGER_BAND[5:0];
			divider_fraction_ch1 <= {rx_cfg_pkg::RST_PLL_FRACTION_HIGH[4:0],
				rx_cfg_pkg::RST_PLL_FRACTION_MID, rx_cfg_pkg::RST_PLL_FRACTION_LOW};
			spur_compensation_enable_ch1 <=
				rx_cfg_pkg::RST_PLL_FRACTION_HIGH[rx_cfg_pkg::POS_SPUR_COMP];
		end else begin
			divider_integer_ch1 <= pll_integer_band_ch1[5:0];
			divider_fraction_ch1 <= {pll_fraction_high_ch1[4:0], pll_fraction_mid_ch1,
				pll_fraction_low_ch1};
			spur_compensation_enable_ch1 <= pll_fraction_high_ch1[rx_cfg_pkg::POS_SPUR_COMP];
		end
	end
endmodule
`default_nettype wire

// ---- verif/rx_cfg_host.sv ----
// host model issuing register accesses on the request port
`timescale 1ns/1ps
`default_nettype none
module rx_cfg_host (
	input wire logic clk,
	output var rx_cfg_pkg::reg_req_t req
);
	initial req = '0;
	// one access: raised after a falling edge, held over the taking edge, then released
	task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(posedge clk);
		@(negedge clk);
		req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule
`default_nettype wire

// ---- verif/rx_cfg_regs_sva.sv ----
// assertions on the configuration register ports
`timescale 1ns/1ps
`default_nettype none
module rx_cfg_regs_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire rx_cfg_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rdata_valid,
	input wire rx_cfg_pkg::proc_ctrl_t proc_ctrl,
	input wire logic channel1_select,
	input wire rx_cfg_pkg::band_t band_select,
	input wire logic [20:0] divider_fraction_ch1,
	input wire logic spur_compensation_enable_ch1,
	input wire logic illegal_write
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic pg;
	// page bit followed from writes to the page register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) pg <= 1'b0;
		else if (req.valid && req.write && req.addr == rx_cfg_pkg::OFS_PAGE_SELECT) pg <= req.wdata[0];
	end
	wire logic w0 = req.valid && req.write && !pg;
	wire logic wcfg = w0 && req.addr == rx_cfg_pkg::OFS_CHANNEL_CONFIG;
	wire logic wint = w0 && req.addr == rx_cfg_pkg::OFS_PLL_INTEGER_BAND;
	wire logic wfl = w0 && req.addr == rx_cfg_pkg::OFS_PLL_FRACTION_LOW;
	wire logic wfh = w0 && req.addr == rx_cfg_pkg::OFS_PLL_FRACTION_HIGH;
	sequence s_rd; req.valid && !req.write; endsequence
	sequence s_fl; wfl ##1 !wfl; endsequence
	sequence s_fh; wfh ##1 !wfh; endsequence
	property p_rd; s_rd |=> rdata_valid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_ch1; channel1_select; endproperty
	a_ch1: assert property (p_ch1) else $error("channel 1 not selected");
	property p_ext1; wcfg && req.wdata[6:5] == 2'b01 |-> ##2 proc_ctrl.chip_data_rx_mode
		&& !proc_ctrl.framing_enable && proc_ctrl.sync_timeout_timer_enable
		&& !proc_ctrl.timeout_timer_enable && proc_ctrl.wakeup_as_sync; endproperty
	a_ext1: assert property (p_ext1) else $error("chip data mode wrong");
	property p_ext2; wcfg && req.wdata[6:5] == 2'b10 |-> ##2 proc_ctrl.matched_filter_rx_mode
		&& !proc_ctrl.frame_interrupts_enable && !proc_ctrl.sync_timeout_timer_enable
		&& proc_ctrl.wakeup_level_only; endproperty
	a_ext2: assert property (p_ext2) else $error("filter data mode wrong");
	property p_ill; wcfg && req.wdata[6:5] == 2'b11 |=> illegal_write; endproperty
	a_ill: assert property (p_ill) else $error("unused mode not flagged");
	property p_band; wint && req.wdata[7:6] == 2'b11 |-> ##2 band_select == rx_cfg_pkg::BAND_315;
	endproperty
	a_band: assert property (p_band) else $error("band 315 not selected");
	property p_band0; wint && req.wdata[7:6] == 2'b00 |=> illegal_write ##1 $stable(band_select);
	endproperty
	a_band0: assert property (p_band0) else $error("unused band not refused");
	property p_frac; s_fl |-> ##1 divider_fraction_ch1[7:0] == $past(req.wdata, 2); endproperty
	a_frac: assert property (p_frac) else $error("fraction low byte wrong");
	property p_spur; s_fh |-> ##1 spur_compensation_enable_ch1 == $past(req.wdata[5], 2);
	endproperty
	a_spur: assert property (p_spur) else $error("spur enable wrong");
	property p_rz; req.valid && !req.write && req.addr == rx_cfg_pkg::OFS_PAGE_SELECT
		|=> rdata[7:1] == 7'h00;
	endproperty
	a_rz: assert property (p_rz) else $error("unused page bits not zero");
endmodule
bind rx_channel_pll_config_regs rx_cfg_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .req(req),
	.rdata(rdata), .rdata_valid(rdata_valid), .proc_ctrl(proc_ctrl), .channel1_select(channel1_select),
	.band_select(band_select), .divider_fraction_ch1(divider_fraction_ch1),
	.spur_compensation_enable_ch1(spur_compensation_enable_ch1), .illegal_write(illegal_write));
`default_nettype wire

// ---- verif/rx_channel_pll_config_regs_tb.sv ----
// testbench for the configuration register group
`timescale 1ns/1ps
`default_nettype none
module rx_channel_pll_config_regs_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	rx_cfg_pkg::reg_req_t req;
	rx_cfg_pkg::proc_ctrl_t proc;
	rx_cfg_pkg::demod_sel_t demod;
	rx_cfg_pkg::band_t band;
	logic [7:0] rdata;
	logic [5:0] dint;
	logic [20:0] frac;
	logic rv, resume, cnt, ch1, spur, ill, psel;
	// FSK flags {slave run, polling, self-poll run} per modulation code 3..0
	logic [11:0] fsk_by_mt = 12'hAB8;
	int n_fail = 0;
	int checked = 0;
	always #12.5 clk = ~clk;
	rx_cfg_host u_host (.clk(clk), .req(req));
	rx_channel_pll_config_regs u_dut (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
		.rdata_valid(rv), .page_select(psel), .proc_ctrl(proc),
		.resume_polling_after_message_end(resume),
		.channel_count(cnt), .channel1_select(ch1), .demod_sel(demod), .band_select(band),
		.divider_integer_ch1(dint), .divider_fraction_ch1(frac), .spur_compensation_enable_ch1(spur),
		.illegal_write(ill));
	// comparison with mismatch report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		u_host.access(1'b1, a, d);
	endtask
	// read ends in the answer cycle
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		u_host.access(1'b0, a, 8'h00);
		chk(rv, 1, "valid");
		chk(rdata, e, "rdata");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#100us;
		n_fail++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		rd(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h04);
		rd(rx_cfg_pkg::OFS_PLL_INTEGER_BAND, 8'h93);
		rd(rx_cfg_pkg::OFS_PLL_FRACTION_LOW, 8'hF3);
		rd(rx_cfg_pkg::OFS_PLL_FRACTION_MID, 8'h07);
		rd(rx_cfg_pkg::OFS_PLL_FRACTION_HIGH, 8'h09);
		rd(rx_cfg_pkg::OFS_PAGE_SELECT, 8'h00);
		chk(frac, 21'h0907F3, "frac");
		chk({band, dint, spur, cnt}, {rx_cfg_pkg::BAND_434, 6'h13, 1'b0, 1'b1}, "outs");
		$display("reset values done");
		for (int x = 0; x < 3; x++) begin
			for (int m = 0; m < 4; m++) begin
				wr(rx_cfg_pkg::OFS_CHANNEL_CONFIG, {1'b0, x[1:0], m[0], 2'b00, m[1:0]});
				@(negedge clk);
				chk(proc, {x == 1, x == 2, x == 2, x == 0, x == 0, x != 2, x == 0, x == 1, x == 2},
					"proc");
				chk(demod, fsk_by_mt[3 * m +: 3], "demod");
				chk({resume, ch1, cnt}, {m[0], 1'b1, 1'b0}, "resume");
			end
		end
		wr(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'hFF);
		chk(ill, 1, "unused mode");
		@(negedge clk);
		chk(ill, 0, "flag one cycle");
		chk(proc, 9'h03C, "unused mode all active");
		chk({ch1, cnt}, 2'h3, "channel");
		rd(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h7F);
		$display("modes done");
		for (int b = 1; b < 4; b++) begin
			wr(rx_cfg_pkg::OFS_PLL_INTEGER_BAND, {b[1:0], 6'h2A});
			@(negedge clk);
			chk({band, dint}, {3'b001 << (b - 1), 6'h2A}, "band");
		end
		wr(rx_cfg_pkg::OFS_PLL_INTEGER_BAND, 8'h15);
		chk(ill, 1, "unused band");
		@(negedge clk);
		chk({band, dint}, {rx_cfg_pkg::BAND_315, 6'h15}, "band hold");
		$display("band done");
		wr(rx_cfg_pkg::OFS_PLL_FRACTION_LOW, 8'h11);
		wr(rx_cfg_pkg::OFS_PLL_FRACTION_MID, 8'h22);
		wr(rx_cfg_pkg::OFS_PLL_FRACTION_HIGH, 8'hFF);
		@(negedge clk);
		chk({frac, spur}, {21'h1F2211, 1'b1}, "frac");
		rd(rx_cfg_pkg::OFS_PLL_FRACTION_HIGH, 8'h3F);
		wr(rx_cfg_pkg::OFS_PLL_FRACTION_HIGH, 8'h0A);
		@(negedge clk);
		chk({frac, spur}, {21'h0A2211, 1'b0}, "spur off");
		$display("fraction done");
		wr(rx_cfg_pkg::OFS_PAGE_SELECT, 8'hFF);
		chk(psel, 1, "page bit set");
		rd(rx_cfg_pkg::OFS_PAGE_SELECT, 8'h01);
		rd(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h00);
		wr(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h20);
		wr(rx_cfg_pkg::OFS_PAGE_SELECT, 8'h00);
		chk(psel, 0, "page bit clear");
		rd(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h7F);
		rd(9'h0FF, 8'h00);
		$display("page done");
		rst_b = 1'b0;
		@(negedge clk);
		rst_b = 1'b1;
		rd(rx_cfg_pkg::OFS_CHANNEL_CONFIG, 8'h04);
		chk(band, rx_cfg_pkg::BAND_434, "band reset");
		$display("second reset done");
		wrap_up;
	end
endmodule
`default_nettype wire
